// *** design/cis_cfg.svh ***
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH

// Address map, low ten bits only
`define CIS_ADDR_W 10
`define CIS_IO_LO 10'h000
`define CIS_IO_HI 10'h01f
`define CIS_ROM0_LO 10'h020
`define CIS_ROM0_HI 10'h0bf
`define CIS_RAM_LO 10'h0c0
`define CIS_RAM_HI 10'h0ff
`define CIS_ROM1_LO 10'h100
`define CIS_ROM1_HI 10'h3f7
`define CIS_VEC_LO 10'h3f8
`define CIS_VEC_HI 10'h3ff
`define CIS_RAM_BYTES 64

// Stack pointer
`define CIS_SP_UPPER 11'h007
`define CIS_SP_RESET 5'h1f

// Vector bases, high byte at the base, low byte at base plus one
`define CIS_VEC_RESET 10'h3fe
`define CIS_VEC_TRAP 10'h3fc
`define CIS_VEC_EXT 10'h3fa
`define CIS_VEC_TIMER 10'h3f8

// Condition code layout and stacking
`define CIS_I_BIT 3
`define CIS_STACK_BYTES 3'h5
`define CIS_LAST_BYTE 3'h4
// A read answers two cycles after issue; sequencer reads in flight at an abort are dropped
`define CIS_FLUSH 2'h2

// Software port offsets and fields
`define CIS_REG_CTRL 8'h00
`define CIS_REG_STATUS 8'h01
`define CIS_REG_SP 8'h02
`define CIS_CTRL_SP_RESET 0
`define CIS_ST_EXT 0
`define CIS_ST_TIMER 1
`define CIS_ST_BUSY 2
`define CIS_ST_PIN 3

`endif

// *** design/cis_pkg.sv ***
package cis_pkg;

  typedef enum logic [2:0] {
    CIS_S_RESET,
    CIS_S_RUN,
    CIS_S_PUSH,
    CIS_S_SEL,
    CIS_S_VEC,
    CIS_S_POP
  } cis_state_e;

  typedef enum logic [1:0] {
    CIS_R_IO,
    CIS_R_ROM,
    CIS_R_RAM,
    CIS_R_VEC
  } cis_region_e;

  typedef logic [7:0] cis_byte_t;

endpackage : cis_pkg

// *** design/cis_mem_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface cis_mem_if;
  logic [9:0] addr;
  cis_pkg::cis_byte_t wdata;
  logic we;
  logic re;
  logic tag;
  cis_pkg::cis_byte_t rdata;
  logic rvalid;
  logic rtag;

  modport master (
    output addr,
    output wdata,
    output we,
    output re,
    output tag,
    input rdata,
    input rvalid,
    input rtag
  );

  modport slave (
    input addr,
    input wdata,
    input we,
    input re,
    input tag,
    output rdata,
    output rvalid,
    output rtag
  );
endinterface : cis_mem_if

`default_nettype wire

// *** design/cis_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cis_cfg.svh"

module cis_mem (
  input wire logic clk_sys,
  input wire logic rst,
  cis_mem_if.slave bus,
  output logic [9:0] far_addr,
  output cis_pkg::cis_byte_t far_wdata,
  output logic far_we,
  output logic far_re,
  output logic far_is_io,
  input wire cis_pkg::cis_byte_t far_rdata
);

  function automatic cis_pkg::cis_region_e region_of(input logic [9:0] a);
    if (a <= `CIS_IO_HI)
      region_of = cis_pkg::CIS_R_IO;
    else if (a >= `CIS_RAM_LO && a <= `CIS_RAM_HI)
      region_of = cis_pkg::CIS_R_RAM;
    else if (a >= `CIS_VEC_LO)
      region_of = cis_pkg::CIS_R_VEC;
    else
      region_of = cis_pkg::CIS_R_ROM;
  endfunction : region_of

  cis_pkg::cis_byte_t ram [`CIS_RAM_BYTES];
  cis_pkg::cis_byte_t ram_q_reg;
  logic s1_ram_reg, s1_valid_reg, s1_tag_reg;

  wire cis_pkg::cis_region_e reg_sel = region_of(bus.addr);
  wire ram_hit = (reg_sel == cis_pkg::CIS_R_RAM);
  wire io_hit = (reg_sel == cis_pkg::CIS_R_IO);
  wire [5:0] ram_idx = bus.addr[5:0];

  // Program memory and vectors are read only; writes there are dropped
  always_ff @(posedge clk_sys) begin
    if (bus.we && ram_hit)
      ram[ram_idx] <= bus.wdata;
    ram_q_reg <= ram[ram_idx];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      far_addr <= 10'h000;
      far_wdata <= 8'h00;
      far_we <= 1'b0;
      far_re <= 1'b0;
      far_is_io <= 1'b0;
      s1_ram_reg <= 1'b0;
      s1_valid_reg <= 1'b0;
      s1_tag_reg <= 1'b0;
      bus.rdata <= 8'h00;
      bus.rvalid <= 1'b0;
      bus.rtag <= 1'b0;
    end else begin
      far_addr <= bus.addr;
      far_wdata <= bus.wdata;
      far_we <= bus.we && io_hit;
      far_re <= bus.re && !ram_hit;
      far_is_io <= io_hit;
      s1_ram_reg <= ram_hit;
      s1_valid_reg <= bus.re;
      s1_tag_reg <= bus.tag;
      bus.rdata <= s1_ram_reg ? ram_q_reg : far_rdata;
      bus.rvalid <= s1_valid_reg;
      bus.rtag <= s1_tag_reg;
    end
  end

endmodule : cis_mem

`default_nettype wire

// *** design/cis_core.sv ***
// What this block does
// - Registers occupy the lowest 32 addresses, 0x000 to 0x01F.
// - Writes to unimplemented bits change nothing; they read zero.
// - 64 bytes of RAM at 0x0C0 to 0x0FF hold the stack.
// - ROM at 0x020-0x0BF and 0x100-0x3F7; vectors at 0x3F8-0x3FF.
// - Decode only the low ten address bits of a 1024-byte space.
// - Stack addresses carry fixed upper bits 00000000111, so 0x0E0-0x0FF.
// - Stack pointer names next free byte, starts 0x0FF, decrements on push.
// - Past 32 pushes the pointer wraps to 0x0FF silently.
// - Stacked program counter high byte has its upper six bits zero.
// - Interrupts wait for instruction end; only reset interrupts one.
// - Hardware interrupt only with mask clear and source enabled.
// - Finish instruction, stack registers, pick the source, then set mask at vector load.
// - Among pending requests, highest vector address is served first.
// - The trap instruction vectors whatever the mask bit says.
// - Vectors: reset 3FE, trap 3FC, external 3FA, timer 3F8.
// - Return restores stacked registers and resumes the saved address.
// - Reset pin low or internal reset loads reset vector, sets mask.
// - Mask bit set blocks every hardware source except reset.
// - Entering external service clears the external request latch.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cis_cfg.svh"

module cis_core (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic internal_reset,
  input wire logic instr_done,
  input wire logic trap_exec,
  input wire logic return_exec,
  input wire logic [15:0] core_pc,
  input wire logic [7:0] core_x,
  input wire logic [7:0] core_a,
  input wire logic [7:0] condition_code_reg,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_we,
  input wire logic cpu_re,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  input wire logic external_request_flag,
  input wire logic external_request_enable,
  input wire logic timer_overflow_flag,
  input wire logic timer_overflow_enable,
  input wire logic periodic_tick_flag,
  input wire logic periodic_tick_enable,
  output logic external_request_clear,
  output logic core_hold,
  output logic load_pc,
  output logic load_ccr,
  output logic load_xa,
  output logic [15:0] pc_out,
  output logic [7:0] x_out,
  output logic [7:0] a_out,
  output logic [7:0] ccr_out,
  output logic [4:0] sp_value,
  output logic [9:0] far_addr,
  output logic [7:0] far_wdata,
  output logic far_we,
  output logic far_re,
  output logic far_is_io,
  input wire logic [7:0] far_rdata,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata
);

  cis_mem_if mbus ();

  cis_mem i_cis_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(mbus),
    .far_addr(far_addr),
    .far_wdata(far_wdata),
    .far_we(far_we),
    .far_re(far_re),
    .far_is_io(far_is_io),
    .far_rdata(far_rdata)
  );

  cis_pkg::cis_state_e state_reg, state_next;
  logic [2:0] cnt_reg;
  logic pend_reg;
  logic [1:0] flush_reg;
  logic trap_reg;
  logic [9:0] vec_base_reg;
  logic [4:0] sp_reg;
  logic [7:0] save_pcl_reg, save_pch_reg, save_x_reg, save_a_reg;
  logic [7:0] save_ccr_reg, vec_hi_reg;
  logic pin_meta_reg, pin_sync_reg;

  // Reset pin is asynchronous to the core clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= reset_pin_n;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire reset_req = !pin_sync_reg || internal_reset;
  wire mask_set = condition_code_reg[`CIS_I_BIT];
  wire ext_pend = external_request_flag && external_request_enable;
  wire timer_pend = (timer_overflow_flag && timer_overflow_enable) ||
                    (periodic_tick_flag && periodic_tick_enable);
  // Only sampled at an instruction boundary, never midway
  wire hw_take = instr_done && !mask_set &&
                 (ext_pend || timer_pend);
  wire boundary = (state_reg == cis_pkg::CIS_S_RUN) && instr_done;
  wire start_trap = boundary && trap_exec;
  wire start_ret = boundary && !trap_exec && return_exec;
  wire start_hw = (state_reg == cis_pkg::CIS_S_RUN) && !trap_exec &&
                  !return_exec && hw_take;
  wire last = (cnt_reg == `CIS_LAST_BYTE);
  wire flushing = (flush_reg != 2'h0); // Stale answers of an aborted run
  wire rd_done = mbus.rvalid && !mbus.rtag && !flushing;
  wire [15:0] stack_word = {`CIS_SP_UPPER, sp_reg};
  wire [4:0] sp_inc = sp_reg + 5'h01;
  wire [15:0] pop_word = {`CIS_SP_UPPER, sp_inc};

  // Select the stacked byte for the current push slot
  logic [7:0] push_byte;
  always_comb begin
    unique case (cnt_reg)
      3'h0: push_byte = save_pcl_reg;
      3'h1: push_byte = save_pch_reg;
      3'h2: push_byte = save_x_reg;
      3'h3: push_byte = save_a_reg;
      default: push_byte = save_ccr_reg;
    endcase
  end

  wire in_push = (state_reg == cis_pkg::CIS_S_PUSH);
  wire in_pop = (state_reg == cis_pkg::CIS_S_POP);
  wire vec_fetch = (state_reg == cis_pkg::CIS_S_VEC) ||
                   (state_reg == cis_pkg::CIS_S_RESET);
  wire seq_re = (in_pop || vec_fetch) && !pend_reg && !flushing;
  wire [9:0] vec_addr = vec_base_reg + {9'h000, cnt_reg[0]};
  wire seq_own = (state_reg != cis_pkg::CIS_S_RUN);

  // Sequencer owns the bus whenever it is not running code
  assign mbus.addr = !seq_own ? cpu_addr[9:0] :
                     in_push ? stack_word[9:0] :
                     in_pop ? pop_word[9:0] : vec_addr;
  assign mbus.wdata = seq_own ? push_byte : cpu_wdata;
  assign mbus.we = seq_own ? in_push : cpu_we;
  assign mbus.re = seq_own ? seq_re : cpu_re;
  assign mbus.tag = !seq_own;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cis_pkg::CIS_S_RESET:
        if (rd_done && cnt_reg[0])
          state_next = cis_pkg::CIS_S_RUN;
      cis_pkg::CIS_S_RUN:
        if (start_trap || start_hw)
          state_next = cis_pkg::CIS_S_PUSH;
        else if (start_ret)
          state_next = cis_pkg::CIS_S_POP;
      cis_pkg::CIS_S_PUSH:
        if (last)
          state_next = cis_pkg::CIS_S_SEL;
      cis_pkg::CIS_S_SEL:
        state_next = cis_pkg::CIS_S_VEC;
      cis_pkg::CIS_S_VEC:
        if (rd_done && cnt_reg[0])
          state_next = cis_pkg::CIS_S_RUN;
      cis_pkg::CIS_S_POP:
        if (rd_done && last)
          state_next = cis_pkg::CIS_S_RUN;
    endcase
    if (reset_req)
      state_next = cis_pkg::CIS_S_RESET;
  end

  wire enter_reset = reset_req;
  wire sp_sw_reset = reg_we && (reg_addr == `CIS_REG_CTRL) &&
                     reg_wdata[`CIS_CTRL_SP_RESET];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= cis_pkg::CIS_S_RESET;
      cnt_reg <= 3'h0;
      pend_reg <= 1'b0;
      flush_reg <= 2'h0;
      vec_base_reg <= `CIS_VEC_RESET;
    end else begin
      state_reg <= state_next;
      if (flushing)
        flush_reg <= flush_reg - 2'h1;
      if (enter_reset && state_reg != cis_pkg::CIS_S_RESET) begin
        cnt_reg <= 3'h0;
        pend_reg <= 1'b0;
        flush_reg <= `CIS_FLUSH;
        vec_base_reg <= `CIS_VEC_RESET;
      end else if (state_reg == cis_pkg::CIS_S_RUN) begin
        cnt_reg <= 3'h0;
        pend_reg <= 1'b0;
      end else if (in_push) begin
        cnt_reg <= last ? 3'h0 : cnt_reg + 3'h1;
      end else if (state_reg == cis_pkg::CIS_S_SEL) begin
        // Stacked copy keeps the mask as sampled, it is set at vector load; pick the source now
        if (trap_reg)
          vec_base_reg <= `CIS_VEC_TRAP;
        else if (ext_pend)
          vec_base_reg <= `CIS_VEC_EXT;
        else
          vec_base_reg <= `CIS_VEC_TIMER;
        cnt_reg <= 3'h0;
      end else begin
        if (seq_re)
          pend_reg <= 1'b1;
        if (rd_done) begin
          pend_reg <= 1'b0;
          cnt_reg <= cnt_reg + 3'h1;
        end
      end
    end
  end

  // Stack pointer: decrement after each push, increment before each pop
  always_ff @(posedge clk_sys) begin
    if (rst || enter_reset)
      sp_reg <= `CIS_SP_RESET;
    else if (in_push)
      sp_reg <= sp_reg - 5'h01;
    else if (in_pop && seq_re)
      sp_reg <= sp_inc;
    else if (sp_sw_reset && !seq_own)
      sp_reg <= `CIS_SP_RESET;
  end

  // Snapshot of the registers taken at the boundary; reused for pops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trap_reg <= 1'b0;
      save_pcl_reg <= 8'h00;
      save_pch_reg <= 8'h00;
      save_x_reg <= 8'h00;
      save_a_reg <= 8'h00;
      save_ccr_reg <= 8'h00;
      vec_hi_reg <= 8'h00;
    end else if (start_trap || start_hw) begin
      trap_reg <= start_trap;
      save_pcl_reg <= core_pc[7:0];
      save_pch_reg <= {6'h00, core_pc[9:8]};
      save_x_reg <= core_x;
      save_a_reg <= core_a;
      save_ccr_reg <= condition_code_reg;
    end else if (rd_done && in_pop) begin
      unique case (cnt_reg)
        3'h0: save_ccr_reg <= mbus.rdata;
        3'h1: save_a_reg <= mbus.rdata;
        3'h2: save_x_reg <= mbus.rdata;
        3'h3: save_pch_reg <= mbus.rdata;
        default: save_pcl_reg <= mbus.rdata;
      endcase
    end else if (rd_done && vec_fetch && !cnt_reg[0]) begin
      vec_hi_reg <= mbus.rdata;
    end
  end

  wire vec_end = rd_done && vec_fetch && cnt_reg[0] && !reset_req;
  wire pop_end = rd_done && in_pop && last && !reset_req;
  wire [7:0] ccr_masked = save_ccr_reg | (8'h01 << `CIS_I_BIT);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_pc <= 1'b0;
      load_ccr <= 1'b0;
      load_xa <= 1'b0;
      pc_out <= 16'h0000;
      x_out <= 8'h00;
      a_out <= 8'h00;
      ccr_out <= 8'h00;
      external_request_clear <= 1'b0;
      core_hold <= 1'b1;
    end else begin
      load_pc <= vec_end || pop_end;
      load_ccr <= vec_end || pop_end;
      load_xa <= pop_end;
      core_hold <= (state_next != cis_pkg::CIS_S_RUN) || reset_req;
      external_request_clear <= (state_reg == cis_pkg::CIS_S_SEL) &&
                                !trap_reg && ext_pend;
      if (vec_end) begin
        pc_out <= {6'h00, vec_hi_reg[1:0], mbus.rdata};
        // Interrupt entry and reset both leave the mask set
        ccr_out <= (state_reg == cis_pkg::CIS_S_RESET) ?
                   (condition_code_reg | (8'h01 << `CIS_I_BIT)) :
                   ccr_masked;
      end else if (pop_end) begin
        pc_out <= {save_pch_reg, mbus.rdata};
        ccr_out <= save_ccr_reg;
        x_out <= save_x_reg;
        a_out <= save_a_reg;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpu_rdata <= 8'h00;
      cpu_rvalid <= 1'b0;
      sp_value <= `CIS_SP_RESET;
    end else begin
      cpu_rdata <= mbus.rdata;
      cpu_rvalid <= mbus.rvalid && mbus.rtag;
      sp_value <= sp_reg;
    end
  end

  // Unused bits read zero and ignore writes
  wire [7:0] status_word = {4'h0, pin_sync_reg, seq_own, timer_pend,
                            ext_pend};
  wire [7:0] reg_read = (reg_addr == `CIS_REG_STATUS) ? status_word :
                        (reg_addr == `CIS_REG_SP) ? {3'h0, sp_reg} :
                        8'h00;

  always_ff @(posedge clk_sys) begin
    if (rst || !reg_re)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_read;
  end

endmodule : cis_core

`default_nettype wire

// *** sim/cis_core_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module cis_core_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_done,
  input wire logic trap_exec,
  input wire logic return_exec,
  input wire logic [7:0] condition_code_reg,
  input wire logic cpu_re,
  input wire logic cpu_rvalid,
  input wire logic core_hold,
  input wire logic external_request_flag,
  input wire logic external_request_enable,
  input wire logic external_request_clear,
  input wire logic load_pc,
  input wire logic load_ccr,
  input wire logic load_xa,
  input wire logic [15:0] pc_out,
  input wire logic [7:0] ccr_out,
  input wire logic [4:0] sp_value,
  input wire logic [9:0] far_addr,
  input wire logic far_we,
  input wire logic far_re,
  input wire logic far_is_io
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  logic take;
  logic hw;
  assign take = instr_done && !core_hold;
  assign hw = take && !trap_exec && !return_exec;

  a_we_io_only: assert property (
    far_we |-> far_is_io && far_addr[9:5] == 5'h00)
    else $error("far write outside register area");
  a_read_lat: assert property (
    cpu_re && !core_hold |-> ##3 cpu_rvalid)
    else $error("read answer late");
  a_sp_push: assert property (
    take && trap_exec |-> ##7 sp_value == $past(sp_value, 7) - 5'd5)
    else $error("stack pointer not moved by five");
  a_trap_vec: assert property (
    take && trap_exec |-> ##[6:9] (far_re && far_addr == 10'h3fc))
    else $error("trap vector not fetched");
  a_ext_clear: assert property (
    hw && !condition_code_reg[3] && external_request_flag &&
    external_request_enable |-> ##[6:8] external_request_clear)
    else $error("external latch not cleared");
  a_masked_idle: assert property (
    hw && condition_code_reg[3] |=> !core_hold)
    else $error("masked request was taken");
  a_entry_mask: assert property (
    load_ccr && !load_xa |-> ccr_out[3])
    else $error("mask bit not set on entry");
  a_pc_upper: assert property (
    load_pc |-> pc_out[15:10] == 6'h00)
    else $error("upper program counter bits not zero");
  a_reset_fetch: assert property (
    $fell(rst) |-> ##[0:3] (far_re && far_addr == 10'h3fe))
    else $error("reset vector not fetched");

  c_trap: cover property (take && trap_exec);
  c_ext: cover property (external_request_clear);
  c_ret: cover property (load_xa);
endmodule : cis_core_asserts

bind cis_core cis_core_asserts i_cis_core_asserts (.*);

`default_nettype wire

// *** sim/cis_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cis_far_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [9:0] far_addr,
  input wire logic [7:0] far_wdata,
  input wire logic far_we,
  input wire logic far_re,
  input wire logic ext_set,
  input wire logic external_request_clear,
  output logic [7:0] far_rdata,
  output logic external_request_flag
);
  logic [7:0] io_mem [32];
  logic [7:0] val;

  // Every service address differs, so a wrong vector shows up at once
  always_comb begin
    case (far_addr)
      10'h3f8: val = 8'h01;
      10'h3f9: val = 8'h80;
      10'h3fa: val = 8'h03;
      10'h3fb: val = 8'h60;
      10'h3fc: val = 8'h02;
      10'h3fd: val = 8'h40;
      10'h3fe: val = 8'h01;
      10'h3ff: val = 8'h23;
      default: begin
        if (far_addr[9:5] == 5'h00) begin
          val = io_mem[far_addr[4:0]];
        end else begin
          val = far_addr[7:0] ^ 8'h5a;
        end
      end
    endcase
  end
  // Outside a read the bus shows the inverse, so stale data cannot pass
  assign far_rdata = far_re ? val : ~val;

  always_ff @(posedge clk_sys) begin
    if (far_we) begin
      io_mem[far_addr[4:0]] <= far_wdata;
    end
    if (rst) begin
      external_request_flag <= 1'b0;
    end else if (ext_set) begin
      external_request_flag <= 1'b1;
    end else if (external_request_clear) begin
      external_request_flag <= 1'b0;
    end
  end
endmodule : cis_far_model

`default_nettype wire

// *** sim/cis_core_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module cis_core_test;
  logic clk_sys, rst, reset_pin_n, internal_reset, instr_done, trap_exec;
  logic return_exec, cpu_we, cpu_re, cpu_rvalid, reg_we, reg_re, ext_set;
  logic external_request_flag, external_request_enable;
  logic external_request_clear, timer_overflow_flag, timer_overflow_enable;
  logic periodic_tick_flag, periodic_tick_enable, core_hold;
  logic load_pc, load_ccr, load_xa, far_we, far_re, far_is_io;
  logic [15:0] core_pc, cpu_addr, pc_out;
  logic [7:0] core_x, core_a, condition_code_reg, cpu_wdata, cpu_rdata;
  logic [7:0] x_out, a_out, ccr_out, far_wdata, far_rdata, reg_rdata, d;
  logic [7:0] reg_addr, reg_wdata;
  logic [4:0] sp_value, sp_exp;
  logic [9:0] far_addr;
  logic [31:0] rows [8] = '{32'hfc053c3c, 32'h001f8181, 32'h00c01111,
    32'h04ff2222, 32'h0020777a, 32'h00bf77e5, 32'h03f777ad, 32'h03fe7701};
  logic [7:0] stk [5] = '{8'h55, 8'h01, 8'h12, 8'h34, 8'h00};
  int bad_count, samples_checked;

  cis_core i_cis_core (.*);
  cis_far_model i_cis_far_model (.*);

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_for(input logic want_rv);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n > 80) begin
        bad_count++;
        end_sim();
      end
    end while (want_rv ? cpu_rvalid !== 1'b1 : core_hold !== 1'b0);
  endtask : wait_for

  task automatic cpu_acc(input logic [15:0] ad, input logic [7:0] wd,
                         input logic wr, output logic [7:0] rd);
    @(posedge clk_sys);
    cpu_addr <= ad;
    cpu_wdata <= wd;
    cpu_we <= wr;
    cpu_re <= !wr;
    @(posedge clk_sys);
    cpu_we <= 1'b0;
    cpu_re <= 1'b0;
    rd = 8'h00;
    if (!wr) begin
      wait_for(1'b1);
      rd = cpu_rdata;
    end
  endtask : cpu_acc

  task automatic reg_acc(input logic [7:0] ad, input logic [7:0] wd,
                         input logic wr, output logic [7:0] rd);
    @(posedge clk_sys);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_we <= wr;
    reg_re <= !wr;
    @(posedge clk_sys);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    @(negedge clk_sys);
    rd = reg_rdata;
  endtask : reg_acc

  task automatic step(input logic t, input logic r);
    @(posedge clk_sys);
    instr_done <= 1'b1;
    trap_exec <= t;
    return_exec <= r;
    @(posedge clk_sys);
    instr_done <= 1'b0;
    trap_exec <= 1'b0;
    return_exec <= 1'b0;
    wait_for(1'b0);
  endtask : step

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b1;
    {internal_reset, instr_done, trap_exec, return_exec, cpu_we, cpu_re} = '0;
    {reg_we, reg_re, ext_set, timer_overflow_flag, periodic_tick_flag} = '0;
    {external_request_enable, timer_overflow_enable} = '1;
    periodic_tick_enable = 1'b1;
    {core_pc, cpu_addr, core_x, core_a, cpu_wdata, reg_addr, reg_wdata} = '0;
    condition_code_reg = 8'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    wait_for(1'b0);
    chk(pc_out, 16'h0123);
    chk(ccr_out, 8'h08);
    chk(sp_value, 5'h1f);
    $display("done: reset");
    foreach (rows[i]) begin
      cpu_acc(rows[i][31:16], rows[i][15:8], 1'b1, d);
      cpu_acc(rows[i][31:16], 8'h00, 1'b0, d);
      chk(d, rows[i][7:0]);
    end
    $display("done: address map");
    @(posedge clk_sys);
    condition_code_reg <= 8'h08;
    ext_set <= 1'b1;
    @(posedge clk_sys);
    ext_set <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(core_hold, 1'b0);
    step(1'b0, 1'b0);
    chk(core_hold, 1'b0);
    chk(sp_value, 5'h1f);
    $display("done: masked request");
    @(posedge clk_sys);
    condition_code_reg <= 8'h00;
    timer_overflow_flag <= 1'b1;
    core_pc <= 16'hfd55;
    core_x <= 8'h12;
    core_a <= 8'h34;
    step(1'b0, 1'b0);
    chk(pc_out, 16'h0360);
    chk(ccr_out, 8'h08);
    chk(external_request_flag, 1'b0);
    chk(sp_value, 5'h1a);
    foreach (stk[i]) begin
      cpu_acc(16'h00ff - 16'(i), 8'h00, 1'b0, d);
      chk(d, stk[i]);
    end
    $display("done: priority entry");
    @(posedge clk_sys);
    timer_overflow_flag <= 1'b0;
    periodic_tick_flag <= 1'b1;
    core_pc <= 16'h0277;
    core_x <= 8'h9a;
    core_a <= 8'hbc;
    condition_code_reg <= 8'h01;
    step(1'b0, 1'b0);
    chk(pc_out, 16'h0180);
    @(posedge clk_sys);
    periodic_tick_flag <= 1'b0;
    step(1'b0, 1'b1);
    chk(pc_out, 16'h0277);
    chk({x_out, a_out}, 16'h9abc);
    chk(ccr_out, 8'h01);
    chk(sp_value, 5'h1a);
    $display("done: return");
    @(posedge clk_sys);
    condition_code_reg <= 8'h08;
    sp_exp = 5'h1a;
    // Seven traps push 35 bytes, so the pointer passes the bottom once
    repeat (7) begin
      step(1'b1, 1'b0);
      sp_exp = sp_exp - 5'd5;
      chk(pc_out, 16'h0240);
      chk(sp_value, sp_exp);
    end
    $display("done: trap and wrap");
    reg_acc(8'h02, 8'h00, 1'b0, d);
    chk(d, {3'h0, sp_exp});
    reg_acc(8'h07, 8'h00, 1'b0, d);
    chk(d, 8'h00);
    reg_acc(8'h00, 8'hfe, 1'b1, d);
    @(negedge clk_sys);
    chk(sp_value, sp_exp);
    reg_acc(8'h00, 8'h01, 1'b1, d);
    @(negedge clk_sys);
    chk(sp_value, 5'h1f);
    reg_acc(8'h01, 8'h00, 1'b0, d);
    chk(d, 8'h08);
    $display("done: register port");
    @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    wait_for(1'b0);
    chk(pc_out, 16'h0123);
    @(posedge clk_sys);
    instr_done <= 1'b1;
    return_exec <= 1'b1;
    @(posedge clk_sys);
    instr_done <= 1'b0;
    return_exec <= 1'b0;
    repeat (4) @(posedge clk_sys);
    internal_reset <= 1'b1;
    @(posedge clk_sys);
    internal_reset <= 1'b0;
    wait_for(1'b0);
    chk(pc_out, 16'h0123);
    chk(ccr_out, 8'h08);
    $display("done: reset sources");
    end_sim();
  end
endmodule : cis_core_test

`default_nettype wire
